// file: hdl/prc_pkg.sv
// Package for the pad register cell: register map, control layout, resets.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package prc_pkg;

  // Register byte offsets
  localparam logic [3:0] PRC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] PRC_OFS_STATUS = 4'h4;
  localparam logic [3:0] PRC_OFS_LAG    = 4'h8;

  localparam int PRC_ADDR_W = 4;
  localparam int PRC_DATA_W = 32;
  localparam int PRC_LAG_W  = 5;
  localparam int PRC_CTRL_W = 7;

  // Control register, bit 0 upward: bypass, fix_lag_en, dyn_lag_en,
  // ddr_in, ddr_out, strobe_en, sr_val
  typedef struct packed {
    logic sr_val;
    logic strobe_en;
    logic ddr_out;
    logic ddr_in;
    logic dyn_lag_en;
    logic fix_lag_en;
    logic bypass;
  } prc_ctrl_type;

  localparam prc_ctrl_type   PRC_CTRL_RST = 7'h00;
  localparam logic [4:0]     PRC_LAG_RST  = 5'h00;
  localparam logic [4:0]     PRC_LAG_MAX  = 5'h1f;

  // Status register, bit 0 upward
  typedef struct packed {
    logic [4:0] lag_total;
    logic       phase;
    logic       tri_out;
    logic       buf_out;
    logic       fall;
    logic       rise;
    logic       pin;
  } prc_status_type;

  localparam int PRC_STATUS_W = 11;

endpackage

// file: hdl/prc_lag_line.sv
// Delay line for the conditioned pad input: one tap per clock cycle.
// Assumes the tap select is stable or may change at any cycle boundary.
`timescale 1ns/1ps
module prc_lag_line
  import prc_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 din_i,
  input  wire logic [PRC_LAG_W-1:0] lag_i,
  output logic                      dout_o
);

  logic [DEPTH-1:0] taps_reg;
  logic             dout_reg;

  // Tap 0 is one cycle after the input; each further tap adds a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taps_reg <= '0;
      dout_reg <= 1'b0;
    end else begin
      taps_reg <= {taps_reg[DEPTH-2:0], din_i};
      dout_reg <= taps_reg[lag_i];
    end
  end

  assign dout_o = dout_reg;

endmodule // prc_lag_line

// file: hdl/prc_cell.sv
// Pad register cell: input, output and tri-state register sections with
// bypass, fixed and run-time input lag, SDR and DDR capture, strobe mode.
// Assumes one 40 MHz clock, synchronous reset, and an Avalon-MM master
// that holds its request until it samples waitrequest low.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module prc_cell
  import prc_pkg::*;
#(
  parameter bit IS_RIGHT_EDGE  = 1'b1,
  parameter bit IS_BOTTOM_EDGE = 1'b1,
  parameter int LAG_DEPTH      = 32
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  input  wire logic [PRC_ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [PRC_DATA_W-1:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic      [PRC_DATA_W-1:0] AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  input  wire logic                  PIN_IN_I,
  output logic                       BYPASS_IN_O,
  output logic                       BYPASS_CLK_O,
  output logic                       RISE_SAMPLE_O,
  output logic                       FALL_SAMPLE_O,
  input  wire logic                  CORE_OUT_A_I,
  input  wire logic                  CORE_OUT_B_I,
  output logic                       BUFFER_OUT_O,
  input  wire logic                  TRISTATE_CTL_I,
  output logic                       TRISTATE_OUT_O,
  input  wire logic                  LOCAL_SETRESET_I,
  input  wire logic                  CLOCK_GATE_I,
  input  wire logic [PRC_LAG_W-1:0]  DYN_LAG_SEL_I,
  input  wire logic                  STROBE_RD_SHIFT_I,
  input  wire logic                  STROBE_WR_SHIFT_I,
  input  wire logic                  DUAL_EDGE_POL_I
);

  typedef struct packed {
    // Bus slave
    logic                  av_wait;
    logic [PRC_DATA_W-1:0] rd_data;
    prc_ctrl_type          ctrl;
    logic [PRC_LAG_W-1:0]  fixed_lag;
    // Pin and strobe conditioning
    logic [2:0]            pin_sync;
    logic                  pin_val;
    logic [2:0]            rd_sync;
    logic                  rd_val;
    logic                  rd_prev;
    logic [2:0]            wr_sync;
    logic                  wr_val;
    logic                  wr_prev;
    // Input section
    logic                  byp;
    logic                  rise_q;
    logic                  fall_q;
    // Output and tri-state sections
    logic                  phase;
    logic                  buf_out;
    logic                  tri_out;
  } prc_state_type;

  localparam prc_state_type STATE_RST = '{
    av_wait:   1'b1,
    rd_data:   32'h0000_0000,
    ctrl:      PRC_CTRL_RST,
    fixed_lag: PRC_LAG_RST,
    pin_sync:  3'h0,
    pin_val:   1'b0,
    rd_sync:   3'h0,
    rd_val:    1'b0,
    rd_prev:   1'b0,
    wr_sync:   3'h0,
    wr_val:    1'b0,
    wr_prev:   1'b0,
    byp:       1'b0,
    rise_q:    1'b0,
    fall_q:    1'b0,
    phase:     1'b0,
    buf_out:   1'b0,
    tri_out:   1'b0
  };

  // A change counts once the second and third stages agree
  function automatic logic settle(input logic [2:0] chain,
                                  input logic       held);
    settle = (chain[1] == chain[2]) ? chain[2] : held;
  endfunction

  // Lag sum, saturating at the last tap
  function automatic logic [PRC_LAG_W-1:0] lag_sum(
    input logic [PRC_LAG_W-1:0] a,
    input logic [PRC_LAG_W-1:0] b);
    logic [PRC_LAG_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    lag_sum = s[PRC_LAG_W] ? PRC_LAG_MAX : s[PRC_LAG_W-1:0];
  endfunction

  prc_state_type        s_reg;
  prc_state_type        s_next;
  logic                 fall_neg_reg;
  logic                 lag_out;
  logic [PRC_LAG_W-1:0] fix_part;
  logic [PRC_LAG_W-1:0] dyn_part;
  logic [PRC_LAG_W-1:0] lag_total;
  logic                 use_lag;
  logic                 src;
  logic                 strobe_in;
  logic                 strobe_out;
  logic                 pol_swap;
  prc_status_type       status;

  // Fixed lag and, on bottom cells only, the run-time lag add up
  assign fix_part  = s_reg.ctrl.fix_lag_en ? s_reg.fixed_lag
                                           : PRC_LAG_RST;
  assign dyn_part  = (IS_BOTTOM_EDGE && s_reg.ctrl.dyn_lag_en)
                   ? DYN_LAG_SEL_I : PRC_LAG_RST;
  assign lag_total = lag_sum(fix_part, dyn_part);
  assign use_lag   = s_reg.ctrl.fix_lag_en
                   | (IS_BOTTOM_EDGE & s_reg.ctrl.dyn_lag_en);
  assign src       = use_lag ? lag_out : s_reg.pin_val;

  // Strobe clocks and polarity only exist on right-edge cells
  assign strobe_in  = IS_RIGHT_EDGE & s_reg.ctrl.strobe_en
                    & s_reg.ctrl.ddr_in;
  assign strobe_out = IS_RIGHT_EDGE & s_reg.ctrl.strobe_en
                    & s_reg.ctrl.ddr_out;
  assign pol_swap   = IS_RIGHT_EDGE & DUAL_EDGE_POL_I;

  assign status = '{
    lag_total: lag_total,
    phase:     s_reg.phase,
    tri_out:   s_reg.tri_out,
    buf_out:   s_reg.buf_out,
    fall:      s_reg.fall_q,
    rise:      s_reg.rise_q,
    pin:       s_reg.pin_val
  };

  prc_lag_line #(
    .DEPTH (LAG_DEPTH)
  ) u_lag (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .din_i  (s_reg.pin_val),
    .lag_i  (lag_total),
    .dout_o (lag_out)
  );

  always_comb begin
    s_next = s_reg;

    // Register bus: a request is answered one cycle after it is seen
    s_next.av_wait = 1'b1;
    if ((AVS_READ_I || AVS_WRITE_I) && s_reg.av_wait) begin
      s_next.av_wait = 1'b0;
      s_next.rd_data = 32'h0000_0000;
      unique case (AVS_ADDRESS_I)
        PRC_OFS_CTRL:   s_next.rd_data[PRC_CTRL_W-1:0] = s_reg.ctrl;
        PRC_OFS_STATUS: s_next.rd_data[PRC_STATUS_W-1:0] = status;
        PRC_OFS_LAG:    s_next.rd_data[PRC_LAG_W-1:0] = s_reg.fixed_lag;
        default:        s_next.rd_data = 32'h0000_0000;
      endcase
    end
    // Writes land on the edge at which waitrequest is seen low
    if (AVS_WRITE_I && !s_reg.av_wait && AVS_BYTEENABLE_I[0]) begin
      unique case (AVS_ADDRESS_I)
        PRC_OFS_CTRL:
          s_next.ctrl = AVS_WRITEDATA_I[PRC_CTRL_W-1:0];
        PRC_OFS_LAG:
          s_next.fixed_lag = AVS_WRITEDATA_I[PRC_LAG_W-1:0];
        default: ;
      endcase
    end

    // Pad and strobe inputs pass three stages before use
    s_next.pin_sync = {s_reg.pin_sync[1:0], PIN_IN_I};
    s_next.pin_val  = settle(s_reg.pin_sync, s_reg.pin_val);
    s_next.rd_sync  = {s_reg.rd_sync[1:0], STROBE_RD_SHIFT_I};
    s_next.rd_val   = settle(s_reg.rd_sync, s_reg.rd_val);
    s_next.wr_sync  = {s_reg.wr_sync[1:0], STROBE_WR_SHIFT_I};
    s_next.wr_val   = settle(s_reg.wr_sync, s_reg.wr_val);

    if (LOCAL_SETRESET_I) begin
      // Cell registers take the configured set or reset level
      s_next.byp     = s_reg.ctrl.sr_val;
      s_next.rise_q  = s_reg.ctrl.sr_val;
      s_next.fall_q  = s_reg.ctrl.sr_val;
      s_next.buf_out = s_reg.ctrl.sr_val;
      s_next.tri_out = s_reg.ctrl.sr_val;
      s_next.phase   = 1'b0;
      s_next.rd_prev = s_reg.rd_val;
      s_next.wr_prev = s_reg.wr_val;
    end else if (CLOCK_GATE_I) begin
      s_next.rd_prev = s_reg.rd_val;
      s_next.wr_prev = s_reg.wr_val;

      // Bypass path skips the lag line and capture registers
      s_next.byp = s_reg.pin_val;

      // Input section, frozen while bypass is selected
      if (!s_reg.ctrl.bypass) begin
        if (strobe_in) begin
          // Read strobe edges replace the system clock edges
          if (s_reg.rd_val && !s_reg.rd_prev) begin
            if (pol_swap) begin
              s_next.fall_q = src;
            end else begin
              s_next.rise_q = src;
            end
          end
          if (!s_reg.rd_val && s_reg.rd_prev) begin
            if (pol_swap) begin
              s_next.rise_q = src;
            end else begin
              s_next.fall_q = src;
            end
          end
        end else if (s_reg.ctrl.ddr_in) begin
          // Falling-edge capture is retimed onto the rising edge
          s_next.rise_q = pol_swap ? fall_neg_reg : src;
          s_next.fall_q = pol_swap ? src : fall_neg_reg;
        end else begin
          s_next.fall_q = src;
        end
      end

      // Output section: a every cycle in SDR, b then a in DDR
      if (s_reg.ctrl.ddr_out) begin
        if (strobe_out) begin
          if (s_reg.wr_val != s_reg.wr_prev) begin
            s_next.phase = ~s_reg.phase;
          end
        end else begin
          s_next.phase = ~s_reg.phase;
        end
        s_next.buf_out = s_next.phase ? CORE_OUT_B_I
                                      : CORE_OUT_A_I;
      end else begin
        s_next.phase   = 1'b0;
        s_next.buf_out = CORE_OUT_A_I;
      end

      // Tri-state section
      s_next.tri_out = TRISTATE_CTL_I;
    end else begin
      // Edge trackers follow the strobes so no stale edge fires later
      s_next.rd_prev = s_reg.rd_val;
      s_next.wr_prev = s_reg.wr_val;
    end
  end

  // All three sections run on the one system clock
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Falling-edge half of the generic DDR capture
  always_ff @(negedge CLK_I) begin
    if (RST_I) begin
      fall_neg_reg <= 1'b0;
    end else if (LOCAL_SETRESET_I) begin
      fall_neg_reg <= s_reg.ctrl.sr_val;
    end else if (CLOCK_GATE_I && !s_reg.ctrl.bypass) begin
      fall_neg_reg <= src;
    end
  end

  assign AVS_READDATA_O    = s_reg.rd_data;
  assign AVS_WAITREQUEST_O = s_reg.av_wait;
  assign BYPASS_IN_O       = s_reg.byp;
  assign BYPASS_CLK_O      = s_reg.byp;
  assign RISE_SAMPLE_O     = s_reg.rise_q;
  assign FALL_SAMPLE_O     = s_reg.fall_q;
  assign BUFFER_OUT_O      = s_reg.buf_out;
  assign TRISTATE_OUT_O    = s_reg.tri_out;

endmodule // prc_cell

// file: tb/prc_cell_monitor.sv
// Checker for the pad register cell: bus handshake and data paths.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module prc_cell_monitor
  import prc_pkg::*;
(
  input wire logic                  CLK_I,
  input wire logic                  RST_I,
  input wire logic                  AVS_READ_I,
  input wire logic                  AVS_WRITE_I,
  input wire logic [PRC_DATA_W-1:0] AVS_READDATA_O,
  input wire logic                  AVS_WAITREQUEST_O,
  input wire logic                  PIN_IN_I,
  input wire logic                  BYPASS_IN_O,
  input wire logic                  BYPASS_CLK_O,
  input wire logic                  RISE_SAMPLE_O,
  input wire logic                  FALL_SAMPLE_O,
  input wire logic                  BUFFER_OUT_O,
  input wire logic                  TRISTATE_CTL_I,
  input wire logic                  TRISTATE_OUT_O,
  input wire logic                  LOCAL_SETRESET_I,
  input wire logic                  CLOCK_GATE_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_taken;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_pin_quiet;
    ($stable(PIN_IN_I) && CLOCK_GATE_I && !LOCAL_SETRESET_I) [*6];
  endsequence
  a_wait_one: assert property (s_taken |=> !AVS_WAITREQUEST_O)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (!AVS_WAITREQUEST_O
    |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  a_rdata_hold: assert property (AVS_WAITREQUEST_O && !AVS_READ_I
    && !AVS_WRITE_I |=> $stable(AVS_READDATA_O))
    else $error("read data changed without a request");
  a_tri_follow: assert property (CLOCK_GATE_I && !LOCAL_SETRESET_I
    |=> TRISTATE_OUT_O == $past(TRISTATE_CTL_I))
    else $error("tristate output does not follow control");
  a_gate_hold: assert property (!CLOCK_GATE_I && !LOCAL_SETRESET_I
    |=> $stable(BUFFER_OUT_O) && $stable(TRISTATE_OUT_O)
    && $stable(RISE_SAMPLE_O) && $stable(FALL_SAMPLE_O))
    else $error("cell register changed while gated");
  a_sr_force: assert property (LOCAL_SETRESET_I |=>
    BUFFER_OUT_O == TRISTATE_OUT_O && RISE_SAMPLE_O == FALL_SAMPLE_O
    && RISE_SAMPLE_O == BUFFER_OUT_O && BYPASS_IN_O == BUFFER_OUT_O)
    else $error("set/reset did not force one common value");
  a_clk_copy: assert property (BYPASS_CLK_O == BYPASS_IN_O)
    else $error("bypass clock differs from bypass data");
  a_pin_pass: assert property (s_pin_quiet
    |-> BYPASS_IN_O == PIN_IN_I)
    else $error("bypass output does not show the settled pad");
endmodule // prc_cell_monitor

bind prc_cell prc_cell_monitor u_prc_cell_monitor (
  .CLK_I(CLK_I), .RST_I(RST_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIN_IN_I(PIN_IN_I),
  .BYPASS_IN_O(BYPASS_IN_O), .BYPASS_CLK_O(BYPASS_CLK_O),
  .RISE_SAMPLE_O(RISE_SAMPLE_O), .FALL_SAMPLE_O(FALL_SAMPLE_O),
  .BUFFER_OUT_O(BUFFER_OUT_O), .TRISTATE_CTL_I(TRISTATE_CTL_I),
  .TRISTATE_OUT_O(TRISTATE_OUT_O), .LOCAL_SETRESET_I(LOCAL_SETRESET_I),
  .CLOCK_GATE_I(CLOCK_GATE_I));

// file: tb/prc_pad_model.sv
// Pad-side model: drives the pad pin and the two strobe clocks.
// Assumes the bench sets the wanted pad level and the strobe run flag.
`timescale 1ns/1ps
module prc_pad_model (
  input  wire logic clk_i,
  input  wire logic lvl_i,
  input  wire logic run_i,
  output logic      pin_o,
  output logic      rd_o,
  output logic      wr_o
);
  logic [2:0] ph_reg;

  // Strobes stand still outside bursts; each level lasts four cycles so
  // the three-stage synchroniser sees it settle; write leads read by two
  always_ff @(posedge clk_i) begin
    pin_o  <= lvl_i;
    ph_reg <= run_i ? ph_reg + 3'h1 : 3'h0;
    rd_o   <= run_i & ph_reg[2];
    wr_o   <= run_i & (ph_reg[2] ^ ph_reg[1]);
  end
endmodule // prc_pad_model

// file: tb/tb.sv
// Testbench for the pad register cell: register table, then hand cases.
// Assumes the pad model drives the pin and strobes.
`timescale 1ns/1ps
module tb;
  import prc_pkg::*;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] d;
    logic [3:0]  b;
    logic [31:0] e;
  } prc_row_type;
  prc_row_type rows [6] = '{'{PRC_OFS_LAG, 32'h3f, 4'hf, 32'h1f},
    '{PRC_OFS_LAG, 32'h05, 4'he, 32'h1f}, '{4'hc, 32'h55, 4'hf, 32'h0},
    '{PRC_OFS_CTRL, 32'hff, 4'hf, 32'h7f},
    '{PRC_OFS_CTRL, 32'h0, 4'hf, 32'h0}, '{PRC_OFS_LAG, 32'h0, 4'hf, 32'h0}};
  logic        clk, rst, rd, wr, lvl, run, pin, srd, swr, ca, cb, tctl;
  logic        srst, gate, pol, wreq, byp, bclk, rise, fall, bout, tout;
  logic [3:0]  adr, be;
  logic [31:0] wdat, rdat, q;
  logic [4:0]  dsel;
  int          errors, checked;

  prc_cell u_prc_cell (
    .CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .PIN_IN_I(pin),
    .BYPASS_IN_O(byp), .BYPASS_CLK_O(bclk), .RISE_SAMPLE_O(rise),
    .FALL_SAMPLE_O(fall), .CORE_OUT_A_I(ca), .CORE_OUT_B_I(cb),
    .BUFFER_OUT_O(bout), .TRISTATE_CTL_I(tctl), .TRISTATE_OUT_O(tout),
    .LOCAL_SETRESET_I(srst), .CLOCK_GATE_I(gate), .DYN_LAG_SEL_I(dsel),
    .STROBE_RD_SHIFT_I(srd), .STROBE_WR_SHIFT_I(swr),
    .DUAL_EDGE_POL_I(pol));
  prc_pad_model u_prc_pad_model (.clk_i(clk), .lvl_i(lvl), .run_i(run),
    .pin_o(pin), .rd_o(srd), .wr_o(swr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("[ERR] waitrequest expected 0 seen 1");
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  initial begin
    {rst, rd, wr, lvl, run, ca, cb, tctl, srst, pol} = 10'h200;
    gate = 1'b1;
    adr = 4'h0;
    be = 4'h0;
    wdat = 32'h0;
    dsel = 5'h0;
    cyc(5);
    rst <= 1'b0;
    bus(1'b0, PRC_OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl_rst", 32'h0, q);
    chk("out_rst", 32'h0, {rise, fall, bout, tout});
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
      bus(1'b0, rows[i].a, 32'h0, 4'hf);
      chk("reg", rows[i].e, q);
    end
    $display("register table done");
    lvl <= 1'b1;
    cyc(3);
    chk("sdr_early", 32'h0, fall);
    cyc(4);
    chk("sdr", 32'h3, {byp, fall});
    bus(1'b0, PRC_OFS_STATUS, 32'h0, 4'hf);
    chk("status_sdr", 32'h5, q);
    wreg(PRC_OFS_CTRL, 32'h2);
    wreg(PRC_OFS_LAG, 32'h3);
    lvl <= 1'b0;
    cyc(7);
    chk("fix_lag_early", 32'h1, {byp, fall});
    cyc(6);
    chk("fix_lag", 32'h0, fall);
    wreg(PRC_OFS_LAG, 32'h0);
    wreg(PRC_OFS_CTRL, 32'h4);
    dsel <= 5'h8;
    lvl <= 1'b1;
    cyc(10);
    chk("dyn_lag_early", 32'h0, fall);
    cyc(8);
    chk("dyn_lag", 32'h1, fall);
    bus(1'b0, PRC_OFS_STATUS, 32'h0, 4'hf);
    chk("status_lag", 32'h205, q);
    wreg(PRC_OFS_CTRL, 32'h1);
    lvl <= 1'b0;
    cyc(8);
    chk("bypass", 32'h1, {byp, fall});
    wreg(PRC_OFS_CTRL, 32'h8);
    cyc(8);
    chk("ddr_low", 32'h0, {rise, fall});
    lvl <= 1'b1;
    pol <= 1'b1;
    cyc(8);
    chk("ddr_high", 32'h3, {rise, fall});
    wreg(PRC_OFS_CTRL, 32'h28);
    lvl <= 1'b0;
    run <= 1'b1;
    cyc(12);
    chk("strobe_first", 32'h2, {rise, fall});
    cyc(8);
    chk("strobe", 32'h0, {rise, fall});
    run <= 1'b0;
    wreg(PRC_OFS_CTRL, 32'h0);
    ca <= 1'b1;
    tctl <= 1'b1;
    cyc(2);
    chk("sdr_out", 32'h3, {bout, tout});
    ca <= 1'b0;
    cb <= 1'b1;
    gate <= 1'b0;
    tctl <= 1'b0;
    cyc(3);
    chk("gated", 32'h3, {bout, tout});
    wreg(PRC_OFS_CTRL, 32'h10);
    gate <= 1'b1;
    cyc(2);
    chk("ddr_out_b", 32'h1, bout);
    cyc(1);
    chk("ddr_out_a", 32'h0, bout);
    wreg(PRC_OFS_CTRL, 32'h40);
    srst <= 1'b1;
    cyc(3);
    chk("setreset", 32'h3f, {bclk, byp, rise, fall, bout, tout});
    srst <= 1'b0;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    bus(1'b0, PRC_OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl_rerst", 32'h0, q);
    $display("hand cases done");
    report_and_stop();
  end
endmodule // tb
